// [logic/bos_pkg.sv]
package bos_pkg;
    // datapath widths
    localparam int BOS_DATA_W  = 8;
    localparam int BOS_FADDR_W = 7;
    localparam int BOS_K_W     = 11;
    localparam int BOS_PC_W    = 15;
    localparam int BOS_LATCH_W = 7;
    // upper program counter bits come from this slice of the latch
    localparam int BOS_LATCH_HI = 6;
    localparam int BOS_LATCH_LO = 3;
    // literal of the or instruction is the low byte of the operand field
    localparam int BOS_LIT_HI   = 7;
    // reset values and unit step constants
    localparam logic [BOS_DATA_W-1:0] BOS_ACC_RST  = 8'h00;
    localparam logic [BOS_PC_W-1:0]   BOS_PC_RST   = 15'h0000;
    localparam logic                  BOS_ZERO_RST = 1'b0;
    localparam logic [BOS_DATA_W-1:0] BOS_ONE      = 8'h01;
    localparam logic [BOS_PC_W-1:0]   BOS_PC_STEP  = 15'h0001;

    // decoded instruction kinds handled by this block
    typedef enum logic [2:0] {
        BOS_OP_NOP,
        BOS_OP_FILE_DECREMENT,
        BOS_OP_ACC_CLEAR,
        BOS_OP_DEC_SKIP_ZERO,
        BOS_OP_INC_SKIP_ZERO,
        BOS_OP_JUMP_ABSOLUTE,
        BOS_OP_OR_LITERAL_ACC
    } bos_op_e;

    // one instruction as offered by fetch
    typedef struct packed {
        bos_op_e                op;
        logic [BOS_FADDR_W-1:0] faddr;
        logic                   select_to_file;
        logic [BOS_K_W-1:0]     k;
    } bos_instr_s;

    // write-back request toward the data register file
    typedef struct packed {
        logic                   we;
        logic [BOS_FADDR_W-1:0] addr;
        logic [BOS_DATA_W-1:0]  data;
    } bos_file_wr_s;
endpackage

// [logic/bos_exec.sv]
`timescale 1ns/1ps
// Functional notes
// RULE1: decrement file, result to acc or file, zero
// RULE2: acc cleared, zero flag forced high
// RULE3: dec-skip decrements, routes result, flags untouched
// RULE4: dec-skip zero result replaces next with nop
// RULE5: inc-skip increments, routes result, flags untouched
// RULE6: inc-skip zero or wrap replaces next with nop
// RULE7: jump loads k and latch bits 6:3
// RULE8: jump takes two cycles, flags untouched
// RULE9: or literal into acc, zero updated
// RULE10: zero set on zero result, else cleared
// RULE11: simple ops one cycle, no-skip one cycle
module bos_exec (
    // clock and reset
    input  wire logic                           i_clk_sys,
    input  wire logic                           i_rst_n,
    // instruction offer from fetch
    input  wire logic                           i_instr_valid,
    input  wire bos_pkg::bos_instr_s            i_instr,
    output logic                                o_ready,
    // operand read from the data register file (addressed by i_instr.faddr)
    input  wire logic [bos_pkg::BOS_DATA_W-1:0] i_file_rd_data,
    // upper program counter latch
    input  wire logic [bos_pkg::BOS_LATCH_W-1:0] i_upper_pc_latch,
    // write-back to the data register file
    output bos_pkg::bos_file_wr_s               o_file_wr,
    // architectural state
    output logic [bos_pkg::BOS_DATA_W-1:0]      o_acc,
    output logic                                o_null_result_flag,
    output logic [bos_pkg::BOS_PC_W-1:0]        o_pc,
    output logic                                o_nop_cycle
);
    import bos_pkg::*;

    // second cycle of a skip or a jump
    typedef enum logic {ST_EXEC, ST_NOP} bos_state_e;

    bos_state_e              state_r, state_nxt;       // issue state
    logic [BOS_DATA_W-1:0]   acc_r, acc_nxt;           // accumulator
    logic                    zero_r, zero_nxt;         // null_result_flag
    logic [BOS_PC_W-1:0]     pc_r, pc_nxt;             // program counter
    bos_file_wr_s            fwr_r, fwr_nxt;           // registered write-back
    logic                    take;                     // instruction accepted
    logic [BOS_DATA_W-1:0]   res;                      // alu result

    // the nop slot blocks new issue, which is what stretches the instruction
    assign o_ready = (state_r == ST_EXEC);
    assign take    = i_instr_valid && o_ready;

    // next-state and datapath
    always_comb begin
        state_nxt = ST_EXEC;                                      // [RULE11]
        acc_nxt   = acc_r;
        zero_nxt  = zero_r;
        pc_nxt    = pc_r;
        fwr_nxt   = '0;
        res       = '0;
        if (state_r == ST_NOP) begin
            // the discarded instruction's slot still advances the counter
            pc_nxt = pc_r + BOS_PC_STEP;
        end else if (take) begin
            pc_nxt = pc_r + BOS_PC_STEP;
            case (i_instr.op)
                BOS_OP_FILE_DECREMENT, BOS_OP_DEC_SKIP_ZERO: begin
                    res = i_file_rd_data - BOS_ONE;                       // [RULE1] [RULE3]
                end
                BOS_OP_INC_SKIP_ZERO: begin
                    res = i_file_rd_data + BOS_ONE;                       // [RULE5]
                end
                BOS_OP_OR_LITERAL_ACC: begin
                    res = acc_r | i_instr.k[BOS_LIT_HI:0];                // [RULE9]
                end
                default: begin
                    res = '0;                                             // [RULE2]
                end
            endcase
            case (i_instr.op)
                BOS_OP_FILE_DECREMENT, BOS_OP_DEC_SKIP_ZERO, BOS_OP_INC_SKIP_ZERO: begin
                    // destination bit picks accumulator or file
                    if (i_instr.select_to_file) begin
                        fwr_nxt = '{we: 1'b1, addr: i_instr.faddr, data: res};
                    end else begin
                        acc_nxt = res;
                    end
                    if (i_instr.op == BOS_OP_FILE_DECREMENT) begin
                        zero_nxt = (res == '0);                           // [RULE10]
                    end else if (res == '0) begin
                        state_nxt = ST_NOP;                               // [RULE4] [RULE6]
                    end
                end
                BOS_OP_ACC_CLEAR: begin
                    acc_nxt  = BOS_ACC_RST;                               // [RULE2]
                    zero_nxt = 1'b1;
                end
                BOS_OP_OR_LITERAL_ACC: begin
                    acc_nxt  = res;
                    zero_nxt = (res == '0);                               // [RULE10]
                end
                BOS_OP_JUMP_ABSOLUTE: begin
                    pc_nxt = {i_upper_pc_latch[BOS_LATCH_HI:BOS_LATCH_LO],
                              i_instr.k};                                 // [RULE7]
                    state_nxt = ST_NOP;                                   // [RULE8]
                end
                default: begin
                    // nop: only the counter moves
                end
            endcase
        end
    end

    // registers only
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_EXEC;
            acc_r   <= BOS_ACC_RST;
            zero_r  <= BOS_ZERO_RST;
            pc_r    <= BOS_PC_RST;
            fwr_r   <= '0;
        end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
            zero_r  <= zero_nxt;
            pc_r    <= pc_nxt;
            fwr_r   <= fwr_nxt;
        end
    end

    // outputs straight from flip-flops
    assign o_acc              = acc_r;
    assign o_null_result_flag = zero_r;
    assign o_pc               = pc_r;
    assign o_file_wr          = fwr_r;
    assign o_nop_cycle        = (state_r == ST_NOP);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    property p_file_dec;
        take && i_instr.op == BOS_OP_FILE_DECREMENT && !i_instr.select_to_file
        |=> o_acc == 8'($past(i_file_rd_data) - BOS_ONE) && o_ready
            && o_null_result_flag == ($past(i_file_rd_data) == BOS_ONE);
    endproperty
    a_file_dec: assert property (p_file_dec) else $error("decrement to acc wrong"); // [RULE1]

    property p_file_dec_wr;
        take && i_instr.op == BOS_OP_FILE_DECREMENT && i_instr.select_to_file
        |=> o_file_wr.we && o_file_wr.data == 8'($past(i_file_rd_data) - BOS_ONE)
            && $stable(o_acc);
    endproperty
    a_file_dec_wr: assert property (p_file_dec_wr) else $error("dec to file wrong"); // [RULE1]

    property p_clear;
        take && i_instr.op == BOS_OP_ACC_CLEAR |=> o_acc == '0 && o_null_result_flag && o_ready;
    endproperty
    a_clear: assert property (p_clear) else $error("clear result wrong"); // [RULE2]

    property p_skip_flags;
        take && (i_instr.op == BOS_OP_DEC_SKIP_ZERO || i_instr.op == BOS_OP_INC_SKIP_ZERO)
        |=> $stable(o_null_result_flag);
    endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("skip op changed flag"); // [RULE3]

    property p_dec_skip;
        take && i_instr.op == BOS_OP_DEC_SKIP_ZERO
        |=> (o_nop_cycle == ($past(i_file_rd_data) == BOS_ONE))
            && (o_ready == !o_nop_cycle);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("dec skip length wrong"); // [RULE4]

    property p_inc_skip;
        take && i_instr.op == BOS_OP_INC_SKIP_ZERO && !i_instr.select_to_file
        |=> o_acc == 8'($past(i_file_rd_data) + BOS_ONE)
            && (o_nop_cycle == ($past(i_file_rd_data) == 8'hFF));
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("inc skip wrong"); // [RULE5]

    property p_inc_wrap;
        take && i_instr.op == BOS_OP_INC_SKIP_ZERO && i_file_rd_data == 8'hFF
        |=> !o_ready ##1 o_ready;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("wrap did not skip"); // [RULE6]

    property p_jump;
        take && i_instr.op == BOS_OP_JUMP_ABSOLUTE
        |=> o_pc == {$past(i_upper_pc_latch[BOS_LATCH_HI:BOS_LATCH_LO]), $past(i_instr.k)}
            && !o_ready && $stable(o_null_result_flag) ##1 o_ready;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or length wrong"); // [RULE7]

    property p_or;
        take && i_instr.op == BOS_OP_OR_LITERAL_ACC
        |=> o_acc == ($past(o_acc) | $past(i_instr.k[BOS_LIT_HI:0]))
            && o_null_result_flag == (o_acc == '0) && o_ready;
    endproperty
    a_or: assert property (p_or) else $error("or literal wrong"); // [RULE9]

    // simple ops and the nop leave issue open on the next edge
    property p_single;
        take && (i_instr.op == BOS_OP_FILE_DECREMENT || i_instr.op == BOS_OP_ACC_CLEAR
                 || i_instr.op == BOS_OP_OR_LITERAL_ACC || i_instr.op == BOS_OP_NOP)
        |=> o_ready && !o_nop_cycle;
    endproperty
    a_single: assert property (p_single) else $error("simple op not one cycle"); // [RULE11]

    // the bubble slot only advances the counter and reopens issue
    property p_bubble;
        o_nop_cycle
        |=> $stable(o_acc) && $stable(o_null_result_flag) && !o_file_wr.we
            && o_pc == $past(o_pc) + BOS_PC_STEP && o_ready;
    endproperty
    a_bubble: assert property (p_bubble) else $error("bubble slot changed state"); // [RULE4]

    // a skip op aimed at the file writes it and leaves the accumulator alone
    property p_skip_file;
        take && (i_instr.op == BOS_OP_DEC_SKIP_ZERO || i_instr.op == BOS_OP_INC_SKIP_ZERO)
            && i_instr.select_to_file
        |=> o_file_wr.we && o_file_wr.addr == $past(i_instr.faddr) && $stable(o_acc);
    endproperty
    a_skip_file: assert property (p_skip_file) else $error("skip to file wrong"); // [RULE3]

endmodule // bos_exec

// [bench/bos_rf_model.sv]
`timescale 1ns/1ps
// data register file facing the execution block
module bos_rf_model (
    // clock
    input  wire logic                            i_clk_sys,
    // read address and write-back request
    input  wire logic [bos_pkg::BOS_FADDR_W-1:0] i_faddr,
    input  wire bos_pkg::bos_file_wr_s           i_wr,
    // read data, combinational like the real file
    output logic [bos_pkg::BOS_DATA_W-1:0]       o_rd_data
);
    import bos_pkg::*;
    logic [BOS_DATA_W-1:0] mem_r [0:127]; // contents, preloaded by the bench
    assign o_rd_data = mem_r[i_faddr];
    // a write lands at the edge after the pulse, so a same-cycle read sees the old value
    always @(posedge i_clk_sys) begin
        if (i_wr.we) begin
            mem_r[i_wr.addr] <= i_wr.data;
        end
    end
endmodule // bos_rf_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import bos_pkg::*;
    logic                   i_clk_sys = 1'b0;        // 50 MHz
    logic                   i_rst_n = 1'b0;          // active low
    logic                   i_instr_valid = 1'b0;    // offer strobe
    bos_instr_s             i_instr = '0;            // offered instruction
    logic [BOS_LATCH_W-1:0] i_upper_pc_latch = 7'h00; // upper pc source
    logic [BOS_DATA_W-1:0]  rd_data;                 // file read data
    logic                   o_ready, o_null_result_flag, o_nop_cycle;
    bos_file_wr_s           o_file_wr;
    logic [BOS_DATA_W-1:0]  o_acc;
    logic [BOS_PC_W-1:0]    o_pc;
    int                     errors = 0;
    int                     n_tests = 0;
    logic [BOS_PC_W-1:0]    pc_e = 15'h0000;         // expected pc
    always #10 i_clk_sys = ~i_clk_sys;
    bos_exec DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .o_ready(o_ready), .i_file_rd_data(rd_data),
        .i_upper_pc_latch(i_upper_pc_latch), .o_file_wr(o_file_wr), .o_acc(o_acc),
        .o_null_result_flag(o_null_result_flag), .o_pc(o_pc), .o_nop_cycle(o_nop_cycle));
    bos_rf_model u_rf (.i_clk_sys(i_clk_sys), .i_faddr(i_instr.faddr), .i_wr(o_file_wr),
        .o_rd_data(rd_data));
    task end_of_test;
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // state check: nop, ready, flag, acc
    task chk_st(input logic [10:0] exp);
        chk({5'h00, o_nop_cycle, o_ready, o_null_result_flag, o_acc}, {5'h00, exp});
    endtask
    task chk_pc;
        chk({1'b0, o_pc}, {1'b0, pc_e});
    endtask
    // offer and hold until taken; a refusal stretches the wait, and 8 refusals in a row end the test
    task issue(input bos_op_e op, input logic [6:0] fa, input logic d, input logic [10:0] k);
        logic tk;
        tk = 1'b0;
        i_instr_valid = 1'b1;
        i_instr = '{op, fa, d, k};
        for (int i = 0; i < 8 && tk !== 1'b1; i++) begin
            tk = o_ready;
            @(posedge i_clk_sys);
            #1;
        end
        if (tk !== 1'b1) begin
            errors++;
            end_of_test();
        end else begin
            pc_e = pc_e + 15'h0001;
        end
    endtask
    task idle;
        i_instr_valid = 1'b0;
        @(posedge i_clk_sys);
        #1;
    endtask
    // single-cycle ops, both destinations, zero flag both ways
    task s_simple;
        u_rf.mem_r[5] = 8'h01;
        u_rf.mem_r[6] = 8'h00;
        issue(BOS_OP_OR_LITERAL_ACC, 7'h00, 1'b0, 11'h75a);
        chk_st(11'h25a);
        issue(BOS_OP_FILE_DECREMENT, 7'h05, 1'b0, 11'h000);
        chk_st(11'h300);
        issue(BOS_OP_FILE_DECREMENT, 7'h06, 1'b1, 11'h000);
        chk({o_file_wr.we, o_file_wr.addr, o_file_wr.data}, 16'h86ff);
        chk_st(11'h200);
        issue(BOS_OP_OR_LITERAL_ACC, 7'h00, 1'b0, 11'h000);
        chk_st(11'h300);
        issue(BOS_OP_OR_LITERAL_ACC, 7'h00, 1'b0, 11'h0a5);
        chk_st(11'h2a5);
        issue(BOS_OP_ACC_CLEAR, 7'h00, 1'b0, 11'h000);
        chk_st(11'h300);
        issue(BOS_OP_NOP, 7'h00, 1'b0, 11'h000);
        chk_st(11'h300);
        idle();
        chk_pc();
    endtask
    // skip ops: no skip, skip to acc, skip with wrap to file, refusal in the nop slot
    task s_skip;
        u_rf.mem_r[9] = 8'h02;
        u_rf.mem_r[10] = 8'h01;
        u_rf.mem_r[11] = 8'hff;
        u_rf.mem_r[12] = 8'h07;
        issue(BOS_OP_DEC_SKIP_ZERO, 7'h09, 1'b0, 11'h000);
        chk_st(11'h301);
        issue(BOS_OP_OR_LITERAL_ACC, 7'h00, 1'b0, 11'h010);
        chk_st(11'h211);
        issue(BOS_OP_DEC_SKIP_ZERO, 7'h0a, 1'b0, 11'h000);
        chk_st(11'h400);
        pc_e = pc_e + 15'h0001;
        idle();
        chk_pc();
        chk_st(11'h200);
        issue(BOS_OP_INC_SKIP_ZERO, 7'h0b, 1'b1, 11'h000);
        chk_st(11'h400);
        chk({o_file_wr.we, o_file_wr.addr, o_file_wr.data}, 16'h8b00);
        pc_e = pc_e + 15'h0001;
        issue(BOS_OP_INC_SKIP_ZERO, 7'h0c, 1'b0, 11'h000);
        chk_st(11'h208);
        chk_pc();
    endtask
    // jump target, bubble, flag untouched, refused offer taken after the bubble
    task jmp(input logic [6:0] latch, input logic [10:0] k, input logic [14:0] tgt);
        issue(BOS_OP_ACC_CLEAR, 7'h00, 1'b0, 11'h000);
        i_upper_pc_latch = latch;
        issue(BOS_OP_JUMP_ABSOLUTE, 7'h00, 1'b0, k);
        pc_e = tgt;
        chk_pc();
        chk({14'h0000, o_ready, o_null_result_flag}, 16'h0001);
        issue(BOS_OP_OR_LITERAL_ACC, 7'h00, 1'b0, 11'h001);
        pc_e = tgt + 15'h0002;
        chk_pc();
        chk_st(11'h201);
    endtask
    initial begin
        for (int a = 0; a < 128; a++) u_rf.mem_r[a] = 8'h00;
        repeat (16) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        chk_st(11'h200);
        chk_pc();
        s_simple();
        s_skip();
        jmp(7'h5f, 11'h2ab, 15'h5aab);
        jmp(7'h07, 11'h7ff, 15'h07ff);
        idle();
        end_of_test();
    end
endmodule // tb_top
